// ===== rtl/csd_clock_ctrl.v
// Clock source selection, start-up timing and glitch-free domain gating.
//
// Added by the designer: the register offsets and the strobed register port.
`include "csd_defs.vh"

module csd_clock_ctrl #(
  parameter WAKE_16K = 17'h04000,
  parameter WAKE_32K = 17'h08000,
  parameter RST_64K  = 17'h10000
) (
  // Clock and reset
  input  wire       clk_i,
  input  wire       rst_i,
  // Register port
  input  wire [3:0] addr_i,
  input  wire [7:0] wdata_i,
  input  wire       wr_i,
  input  wire       rd_i,
  output reg  [7:0] rdata_o,
  // Pins from other domains
  input  wire       osc_src_i,
  input  wire       wdt_osc_i,
  input  wire       async_src_i,
  input  wire       wake_i,
  // Domain clocks
  output reg        core_clock_o,
  output reg        periph_clock_o,
  output reg        progmem_clock_o,
  output reg        conv_clock_o,
  output reg        async_timer_clock_o,
  // Status
  output reg        exec_en_o,
  output reg        async_detect_o,
  output reg  [1:0] src_class_o,
  output reg        src_reserved_o
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam ST_RESET = 2'h0;
  localparam ST_RUN   = 2'h1;
  localparam ST_SLEEP = 2'h2;
  localparam ST_WAKE  = 2'h3;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Source class of the fuse field; reserved codes fall to RC.
  function [1:0] src_class;
    input [3:0] f;
    begin
      if (f[3])
        src_class = `CSD_SRC_XTAL;
      else if (f[2])
        src_class = `CSD_SRC_LFX;
      else if (f == 4'h0)
        src_class = `CSD_SRC_EXT;
      else
        src_class = `CSD_SRC_RC;
    end
  endfunction

  // Start-up length in source cycles after deep sleep.
  function [16:0] wake_len;
    input [3:0] f;
    input [1:0] s;
    begin
      case (src_class(f))
        `CSD_SRC_XTAL: begin
          if (!f[0])
            wake_len = s[1] ? `CSD_WAKE_1K : `CSD_WAKE_258;
          else if (s == 2'h0)
            wake_len = `CSD_WAKE_1K;
          else
            wake_len = WAKE_16K;
        end
        `CSD_SRC_LFX: wake_len = f[0] ? WAKE_32K : `CSD_WAKE_1K;
        default:      wake_len = `CSD_WAKE_OTHER;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Counting helpers
  // ----------------------------------------------------------------
  // Counter step shared by the reset and wake waits.
  function [16:0] cnt_step;
    input [16:0] c;
    begin
      cnt_step = c + 17'h00001;
    end
  endfunction

  // High when one more counted edge completes a wait of the given length.
  function cnt_done;
    input [16:0] c;
    input [16:0] len;
    begin
      cnt_done = (cnt_step(c) >= len);
    end
  endfunction

  // Rising edge between two synchronised samples, the newer one in bit 0.
  function pin_rise;
    input [1:0] s;
    begin
      pin_rise = s[0] & ~s[1];
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg [2:0] osc_s;
  reg [2:0] wdt_s;
  reg [1:0] asy_s;
  reg [1:0] wake_s;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      osc_s  <= 3'h0;
      wdt_s  <= 3'h0;
      asy_s  <= 2'h0;
      wake_s <= 2'h0;
    end else begin
      osc_s  <= {osc_s[1:0], osc_src_i};
      wdt_s  <= {wdt_s[1:0], wdt_osc_i};
      asy_s  <= {asy_s[0], async_src_i};
      wake_s <= {wake_s[0], wake_i};
    end
  end

  wire osc_edge = pin_rise(osc_s[2:1]);
  wire wdt_edge = pin_rise(wdt_s[2:1]);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [3:0]  fuse_src;
  reg [1:0]  fuse_sut;
  reg        fuse_div8;
  reg [2:0]  sleep_mode;
  reg [1:0]  state;
  reg [16:0] cnt;
  reg [3:0]  dom_en;
  reg [2:0]  pre_cnt;

  wire sleep_go = wr_i & (addr_i == `CSD_ADDR_SLEEP) & wdata_i[`CSD_SLEEP_GO_BIT];

  // Shipped fuse values load on reset; a one bit reads unprogrammed.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fuse_src   <= `CSD_RST_SRC;
      fuse_sut   <= `CSD_RST_SUT;
      fuse_div8  <= `CSD_RST_DIV8;
      sleep_mode <= `CSD_MODE_IDLE;
    end else if (wr_i) begin
      if (addr_i == `CSD_ADDR_FUSE) begin
        fuse_src  <= wdata_i[`CSD_FUSE_SRC_LSB+3:`CSD_FUSE_SRC_LSB];
        fuse_sut  <= wdata_i[`CSD_FUSE_SUT_LSB+1:`CSD_FUSE_SUT_LSB];
        fuse_div8 <= wdata_i[`CSD_FUSE_DIV8_BIT];
      end
      if (addr_i == `CSD_ADDR_SLEEP)
        sleep_mode <= wdata_i[2:0];
    end
  end

  // ----------------------------------------------------------------
  // Start-up and sleep sequencer
  // ----------------------------------------------------------------
  wire deep = (sleep_mode == `CSD_MODE_PDOWN) | (sleep_mode == `CSD_MODE_PSAVE);
  // Reset delay picked by the upper start-up fuse bit.
  wire [16:0] rst_len = fuse_sut[1] ? RST_64K : `CSD_RST_4K;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_RESET;
      cnt   <= 17'h00000;
    end else begin
      case (state)
        ST_RESET: begin
          if (wdt_edge) begin
            if (cnt_done(cnt, rst_len)) begin
              state <= ST_RUN;
              cnt   <= 17'h00000;
            end else begin
              cnt <= cnt_step(cnt);
            end
          end
        end
        ST_RUN: begin
          if (sleep_go)
            state <= ST_SLEEP;
        end
        ST_SLEEP: begin
          if (wake_s[1]) begin
            cnt   <= 17'h00000;
            state <= deep ? ST_WAKE : ST_RUN;
          end
        end
        ST_WAKE: begin
          if (osc_edge) begin
            if (cnt_done(cnt, wake_len(fuse_src, fuse_sut))) begin
              state <= ST_RUN;
              cnt   <= 17'h00000;
            end else begin
              cnt <= cnt_step(cnt);
            end
          end
        end
        default: state <= ST_RESET;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Domain enables: bit 0 core, 1 peripheral, 2 program memory, 3 converter
  // ----------------------------------------------------------------
  reg [3:0] next_dom_en;

  always @* begin
    next_dom_en = 4'h0;
    if (state == ST_RUN) begin
      next_dom_en = 4'hF;
    end else if (state == ST_SLEEP) begin
      case (sleep_mode)
        `CSD_MODE_IDLE:  next_dom_en = 4'hA;
        `CSD_MODE_NOISE: next_dom_en = 4'h8;
        default:         next_dom_en = 4'h0;
      endcase
    end
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dom_en         <= 4'h0;
      exec_en_o      <= 1'b0;
      async_detect_o <= 1'b0;
      src_class_o    <= `CSD_SRC_RC;
      src_reserved_o <= 1'b0;
    end else begin
      dom_en         <= next_dom_en;
      exec_en_o      <= (next_dom_en[0] & (state == ST_RUN));
      async_detect_o <= ~next_dom_en[1];
      src_class_o    <= src_class(fuse_src);
      src_reserved_o <= (fuse_src == 4'h3) | (fuse_src == 4'h1);
    end
  end

  // ----------------------------------------------------------------
  // Glitch-free domain clock generation
  // ----------------------------------------------------------------
  // A domain clock only starts from low and only stops after its high
  // phase completes, so no shortened phase ever reaches the domain.
  // A prescale change is taken over only at a tick, so the phase that runs
  // when the divide-by-eight fuse is written is never cut short.
  reg        div8_eff;
  wire pre_tick = div8_eff | (pre_cnt == 3'h0);
  reg  [3:0] dclk;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div8_eff <= `CSD_RST_DIV8;
    end else if (pre_tick) begin
      div8_eff <= fuse_div8;
    end
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pre_cnt <= 3'h0;
    end else if (!div8_eff) begin
      pre_cnt <= (pre_cnt == `CSD_PRESCALE) ? 3'h0 : pre_cnt + 3'h1;
    end else begin
      pre_cnt <= 3'h0;
    end
  end

  // ----------------------------------------------------------------
  // Domain clock toggles
  // ----------------------------------------------------------------
  integer i;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dclk <= 4'h0;
    end else if (pre_tick) begin
      for (i = 0; i < 4; i = i + 1) begin
        if (dclk[i])
          dclk[i] <= 1'b0;
        else
          dclk[i] <= dom_en[i];
      end
    end
  end

  always @* begin
    core_clock_o    = dclk[0];
    periph_clock_o  = dclk[1];
    progmem_clock_o = dclk[2];
    conv_clock_o    = dclk[3];
  end

  // The async timer clock is never gated by sleep.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i)
      async_timer_clock_o <= 1'b0;
    else
      async_timer_clock_o <= asy_s[1];
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `CSD_ADDR_FUSE:   rdata_o <= {1'b0, fuse_div8, fuse_sut, fuse_src};
        `CSD_ADDR_SLEEP:  rdata_o <= {5'h00, sleep_mode};
        `CSD_ADDR_STATUS: rdata_o <= {src_reserved_o, 1'b0, dom_en, state};
        default:          rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

endmodule // csd_clock_ctrl

// ===== include/csd_defs.vh
// Constants for the clock source select and distribution block.
`ifndef CSD_DEFS_VH
`define CSD_DEFS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CSD_ADDR_FUSE    4'h0
`define CSD_ADDR_SLEEP   4'h1
`define CSD_ADDR_STATUS  4'h2

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CSD_FUSE_SRC_LSB   0
`define CSD_FUSE_SUT_LSB   4
`define CSD_FUSE_DIV8_BIT  6
`define CSD_SLEEP_GO_BIT   7

// ----------------------------------------------------------------
// Reset values of the fuse field
// ----------------------------------------------------------------
`define CSD_RST_SRC   4'h2
`define CSD_RST_SUT   2'h2
`define CSD_RST_DIV8  1'h0

// ----------------------------------------------------------------
// Clock source classes
// ----------------------------------------------------------------
`define CSD_SRC_XTAL  2'h0
`define CSD_SRC_LFX   2'h1
`define CSD_SRC_RC    2'h2
`define CSD_SRC_EXT   2'h3

// ----------------------------------------------------------------
// Sleep modes
// ----------------------------------------------------------------
`define CSD_MODE_IDLE   3'h0
`define CSD_MODE_NOISE  3'h1
`define CSD_MODE_PDOWN  3'h2
`define CSD_MODE_PSAVE  3'h3
`define CSD_MODE_STBY   3'h6

// ----------------------------------------------------------------
// Timing counts in source, watchdog or system clock cycles
// ----------------------------------------------------------------
`define CSD_WAKE_258    17'h00102
`define CSD_WAKE_1K     17'h00400
`define CSD_WAKE_OTHER  17'h00006
`define CSD_RST_4K      17'h01000
`define CSD_PRESCALE    3'h7

`endif

// ===== sim/csd_clock_ctrl_properties.sv
// Port checks for the clock control block.
module csd_props (
  // Clock and reset
  input wire       clk_i,
  input wire       rst_i,
  // Watched ports
  input wire       async_src_i,
  input wire       core_clock_o,
  input wire       periph_clock_o,
  input wire       progmem_clock_o,
  input wire       async_timer_clock_o,
  input wire       exec_en_o,
  input wire       async_detect_o,
  input wire [1:0] src_class_o,
  input wire       src_reserved_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_res; src_reserved_o |-> src_class_o == 2'h2; endproperty
  property p_run; $rose(core_clock_o) |-> exec_en_o || $past(exec_en_o); endproperty
  property p_stop; !exec_en_o [*8] ##1 !exec_en_o [*8] |-> !core_clock_o; endproperty
  property p_per; $rose(periph_clock_o) |-> !async_detect_o || !$past(async_detect_o);
  endproperty
  property p_det; async_detect_o [*8] ##1 async_detect_o [*8] |-> !periph_clock_o; endproperty
  property p_pm; progmem_clock_o == core_clock_o; endproperty
  property p_asy; !$past(rst_i, 1) && !$past(rst_i, 2) && !$past(rst_i, 3)
    |-> async_timer_clock_o == $past(async_src_i, 3); endproperty
  property p_rst; $fell(rst_i) |-> !exec_en_o [*8]; endproperty
  a_res: assert property (p_res) else $error("reserved code decode");
  a_run: assert property (p_run) else $error("core clock without run");
  a_stop: assert property (p_stop) else $error("core clock not stopped");
  a_per: assert property (p_per) else $error("peripheral clock in detect");
  a_det: assert property (p_det) else $error("peripheral clock not stopped");
  a_pm: assert property (p_pm) else $error("memory clock apart");
  a_asy: assert property (p_asy) else $error("timer clock gated");
  a_rst: assert property (p_rst) else $error("early start after reset");
  c_run: cover property ($rose(exec_en_o));
  c_det: cover property ($rose(async_detect_o));
  c_res: cover property (src_reserved_o);
endmodule // csd_props

bind csd_clock_ctrl csd_props props_u (.clk_i(clk_i), .rst_i(rst_i),
  .async_src_i(async_src_i), .core_clock_o(core_clock_o), .periph_clock_o(periph_clock_o),
  .progmem_clock_o(progmem_clock_o), .async_timer_clock_o(async_timer_clock_o),
  .exec_en_o(exec_en_o), .async_detect_o(async_detect_o), .src_class_o(src_class_o),
  .src_reserved_o(src_reserved_o));

// ===== sim/csd_osc_model.sv
// Free running oscillators that feed the clock pins.
module csd_osc_model #(
  parameter int OSC_HALF = 132,
  parameter int WDT_HALF = 172,
  parameter int ASY_HALF = 372
) (
  // Oscillator pins
  output logic osc_o,
  output logic wdt_o,
  output logic asy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Half periods are multiples of 4 ns, so no pin edge meets a rising clock edge.
  initial osc_o = 1'b0;
  initial wdt_o = 1'b0;
  initial asy_o = 1'b0;
  always #OSC_HALF osc_o = ~osc_o;
  always #WDT_HALF wdt_o = ~wdt_o;
  always #ASY_HALF asy_o = ~asy_o;
endmodule // csd_osc_model

// ===== sim/tb.sv
// Self-checking bench for the clock control block.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic       wr_i = 1'b0;
  logic       rd_i = 1'b0;
  logic       wake_i = 1'b0;
  wire  [7:0] rdata;
  wire  [1:0] cls;
  wire        osc, wdt, asy, core, per, pm, conv, aclk, exec, det, rsv;
  int         bad_count = 0;
  int         check_count = 0;
  int         n;
  logic [7:0] v;
  logic [4:0] m;
  logic [2:0] modes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6};
  logic [4:0] masks [5] = '{5'h0B, 5'h03, 5'h01, 5'h01, 5'h01};
  always #50 clk_i = ~clk_i;
  csd_osc_model osc_u (.osc_o(osc), .wdt_o(wdt), .asy_o(asy));
  csd_clock_ctrl #(.WAKE_16K(17'h00010), .WAKE_32K(17'h00020), .RST_64K(17'h00040)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata), .osc_src_i(osc), .wdt_osc_i(wdt), .async_src_i(asy),
    .wake_i(wake_i), .core_clock_o(core), .periph_clock_o(per), .progmem_clock_o(pm),
    .conv_clock_o(conv), .async_timer_clock_o(aclk), .exec_en_o(exec),
    .async_detect_o(det), .src_class_o(cls), .src_reserved_o(rsv));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    d = rdata;
  endtask
  // Counts cycles until execution is allowed; a hang ends the run.
  task automatic wait_exec(output int c);
    c = 0;
    while (exec !== 1'b1) begin
      @(negedge clk_i);
      c++;
      if (c > 3000) begin
        bad_count++;
        give_verdict();
      end
    end
  endtask
  // Returns which of core, peripheral, memory, converter and timer clocks rose.
  task automatic act(output logic [4:0] r);
    logic [4:0] p;
    r = 5'h00;
    p = {core, per, pm, conv, aclk};
    repeat (40) begin
      @(negedge clk_i);
      r = r | ({core, per, pm, conv, aclk} & ~p);
      p = {core, per, pm, conv, aclk};
    end
  endtask
  // Measures one high phase of the core clock in system clock cycles.
  task automatic hi_len(output int c);
    int t;
    t = 0;
    c = 0;
    while (core !== 1'b0 && t < 100) begin
      @(negedge clk_i);
      t++;
    end
    while (core !== 1'b1 && t < 100) begin
      @(negedge clk_i);
      t++;
    end
    while (core === 1'b1 && t < 100) begin
      c++;
      @(negedge clk_i);
      t++;
    end
    if (t >= 100) begin
      bad_count++;
      give_verdict();
    end
  endtask
  function automatic logic [2:0] dec(input int f);
    if (f >= 8) return 3'h0;
    if (f >= 4) return 3'h1;
    if (f == 0) return 3'h3;
    if (f == 2) return 3'h2;
    return 3'h6;
  endfunction
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(4'h0, v);
    check(v, 8'h22);
    wait_exec(n);
    check(8'(n > 150), 8'h01);
    hi_len(n);
    check(8'(n), 8'h08);
    wr(4'h0, 8'h62);
    repeat (20) @(negedge clk_i);
    hi_len(n);
    check(8'(n), 8'h01);
    $display("test start done");
    for (int f = 0; f < 16; f++) begin
      wr(4'h0, {4'h2, 4'(f)});
      repeat (2) @(negedge clk_i);
      check({5'h0, rsv, cls}, {5'h0, dec(f)});
    end
    rd(4'h0, v);
    check(v, 8'h2F);
    wr(4'h0, 8'h22);
    $display("test decode done");
    foreach (modes[i]) begin
      wr(4'h1, 8'h80 | 8'(modes[i]));
      repeat (20) @(negedge clk_i);
      act(m);
      check({3'h0, m}, {3'h0, masks[i]});
      check({7'h0, det}, {7'h0, ~masks[i][3]});
      check({7'h0, exec}, 8'h00);
      rd(4'h2, v);
      check(v, {2'h0, masks[i][1], masks[i][2], masks[i][3], masks[i][4], 2'h2});
      @(posedge clk_i);
      wake_i <= 1'b1;
      wait_exec(n);
      @(posedge clk_i);
      wake_i <= 1'b0;
      check(8'(n > 10), 8'(modes[i] == 3'h2 || modes[i] == 3'h3));
      $display("test sleep %0d done", modes[i]);
    end
    rd(4'h1, v);
    check(v, 8'h06);
    rd(4'hF, v);
    check(v, 8'h00);
    rd(4'h2, v);
    check(v, 8'h3D);
    wr(4'h0, 8'h2F);
    wr(4'h1, 8'h82);
    repeat (20) @(negedge clk_i);
    @(posedge clk_i);
    wake_i <= 1'b1;
    wait_exec(n);
    @(posedge clk_i);
    wake_i <= 1'b0;
    check(8'(n > 30), 8'h01);
    $display("test crystal wake done");
    give_verdict();
  end
endmodule // tb
